// ==== ebcs_pkg.sv ====
// Purpose: Shared constants and types of the external bus cycle sequencer
// Assumes: 24-bit address, 16-bit data, phase lengths counted in phase time units
// Notes:   Lengths in the timing config are stored as raw field codes
package ebcs_pkg;

	// ****************************************
	// Bus widths
	// ****************************************
	localparam int ADDR_W = 24;
	localparam int DATA_W = 16;
	localparam int LEN_W  = 6;

	// ****************************************
	// Phase lengths in phase time units
	// ****************************************
	localparam logic [LEN_W-1:0] ADDR_BASE_LEN  = 6'h01;
	localparam logic [LEN_W-1:0] ACCESS_MIN_LEN = 6'h01;
	localparam logic [LEN_W-1:0] WAIT_LEN       = 6'h01;
	localparam int               ACCESS_MAX_LEN = 32;
	localparam int               ADDR_MAX_LEN   = 5;

	// ****************************************
	// Reset values of the pins
	// ****************************************
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

	// ****************************************
	// Bus cycle phases
	// ****************************************
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_ADDR,
		PH_CMD,
		PH_WSETUP,
		PH_ACCESS,
		PH_HOLD
	} ebcs_phase_e;

	// ****************************************
	// Per chip-select timing config
	// ****************************************
	typedef struct packed {
		logic       mux_mode;      // 1 multiplexed, 0 demultiplexed
		logic       addr_setup;    // 0 one unit, 1 two units
		logic [1:0] window_ext;    // Extra units on window change
		logic [1:0] cmd_delay;     // 0..3 units
		logic       write_setup;   // 0..1 unit
		logic [4:0] access;        // Code n gives n+1 units
		logic [1:0] hold;          // 0..3 units
		logic       ready_en;      // Access ended by handshake
		logic       ready_low;     // Handshake active low
		logic       ready_async;   // Extra sync stage
	} ebcs_cfg_s;

endpackage

// ==== ebcs_timer_if.sv ====
// Purpose: Carrier between the sequencer and its phase timer
// Assumes: Load and length are valid in the same cycle
// Notes:   Last is high in the final cycle of a loaded phase
`timescale 1ns/100ps
`default_nettype none
interface ebcs_timer_if;
	import ebcs_pkg::*;
	logic             load;
	logic [LEN_W-1:0] len;
	logic             last;
	modport seq (output load, output len, input last);
	modport tmr (input load, input len, output last);
endinterface
`default_nettype wire

// ==== ebcs_timer.sv ====
// Purpose: Counts one phase of a bus cycle in phase time units
// Assumes: Length loaded is at least one unit
// Notes:   One unit lasts UNIT_CYCLES system clocks
`timescale 1ns/100ps
`default_nettype none
module ebcs_timer #(
	parameter int UNIT_CYCLES = 1
) (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic clk_en,
	ebcs_timer_if.tmr tif
);
	import ebcs_pkg::*;

	localparam int PRE_W = (UNIT_CYCLES > 1) ? $clog2(UNIT_CYCLES) : 1;
	localparam logic [PRE_W-1:0] PRE_LOAD = PRE_W'(UNIT_CYCLES - 1);

	initial begin
		if (UNIT_CYCLES < 1) $error("UNIT_CYCLES must be at least one");
	end

	typedef struct packed {
		logic             active;
		logic [PRE_W-1:0] pre;
		logic [LEN_W-1:0] units;
	} ebcs_tmr_s;

	ebcs_tmr_s s_q, s_d;

	// Final cycle of the phase
	assign tif.last = s_q.active && (s_q.pre == '0) && (s_q.units == 6'h01);

	// Prescaler and unit count
	always_comb begin
		s_d = s_q;
		if (tif.load) begin
			s_d.active = 1'b1;
			s_d.pre    = PRE_LOAD;
			s_d.units  = tif.len;
		end else if (s_q.active) begin
			if (s_q.pre == '0) begin
				s_d.pre   = PRE_LOAD;
				s_d.units = s_q.units - 6'h01;
				if (s_q.units == 6'h01) s_d.active = 1'b0;
			end else begin
				s_d.pre = s_q.pre - PRE_W'(1);
			end
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_q <= '0;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end
endmodule
`default_nettype wire

// ==== ebcs_sequencer.sv ====
// Purpose: External bus cycle sequencer with five programmable phases
// Assumes: Timing config per window is static while a cycle runs on it
// Notes:   Pin inputs pass two flops, an async handshake three; read data is the synchronised bus value
`timescale 1ns/100ps
`default_nettype none
module ebcs_sequencer #(
	parameter int NUM_CS      = 4,
	parameter int UNIT_CYCLES = 1
) (
	input  wire logic                              sys_clk,
	input  wire logic                              sys_rst,
	input  wire logic                              clk_en,
	input  wire ebcs_pkg::ebcs_cfg_s [NUM_CS-1:0]  cs_cfg,
	input  wire logic                              reference_clock_output_sys_sel,
	input  wire logic                              reference_clock_output_fast_drv,
	input  wire logic                              req_valid,
	output logic                                   req_ready,
	input  wire logic                              req_write,
	input  wire logic [ebcs_pkg::ADDR_W-1:0]       req_addr,
	input  wire logic [ebcs_pkg::DATA_W-1:0]       req_wdata,
	input  wire logic                              req_byte_high,
	input  wire logic [$clog2(NUM_CS+1)-1:0]       req_window,
	output logic                                   rsp_valid,
	output logic [ebcs_pkg::DATA_W-1:0]            rsp_rdata,
	output logic [NUM_CS-1:0]                      cs_n,
	output logic                                   rd_n,
	output logic                                   wr_n,
	output logic                                   byte_high_enable_n,
	output logic                                   ale,
	output logic [ebcs_pkg::ADDR_W-1:0]            dedicated_address_lines,
	output logic [ebcs_pkg::DATA_W-1:0]            dedicated_data_lines_out,
	output logic                                   dedicated_data_lines_oe,
	input  wire logic [ebcs_pkg::DATA_W-1:0]       dedicated_data_lines_in,
	output logic [ebcs_pkg::DATA_W-1:0]            shared_addr_data_lines_out,
	output logic                                   shared_addr_data_lines_oe,
	input  wire logic [ebcs_pkg::DATA_W-1:0]       shared_addr_data_lines_in,
	input  wire logic                              ready_in,
	output logic                                   reference_clock_output
);
	import ebcs_pkg::*;

	localparam int WIN_W = $clog2(NUM_CS + 1);

	initial begin
		if (NUM_CS < 1) $error("NUM_CS must be at least one");
		if (UNIT_CYCLES < 1) $error("UNIT_CYCLES must be at least one");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		ebcs_phase_e       phase;
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              byte_high_enable;
		logic [WIN_W-1:0]  win;
		logic [WIN_W-1:0]  last_win;
		logic              win_seen;
		ebcs_cfg_s         cfg;
		logic [2:0]        rdy_s;
		logic [DATA_W-1:0] dd_s1;
		logic [DATA_W-1:0] dd_s2;
		logic [DATA_W-1:0] ad_s1;
		logic [DATA_W-1:0] ad_s2;
		logic              req_ready;
		logic              rsp_valid;
		logic [DATA_W-1:0] rsp_rdata;
		logic [NUM_CS-1:0] cs_n;
		logic              rd_n;
		logic              wr_n;
		logic              bhe_n;
		logic              ale;
		logic [ADDR_W-1:0] a_out;
		logic [DATA_W-1:0] d_out;
		logic              d_oe;
		logic [DATA_W-1:0] ad_out;
		logic              ad_oe;
		logic              refclk_en;
	} ebcs_state_s;

	ebcs_state_s s_q, s_d;
	ebcs_timer_if tif ();

	ebcs_timer #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_timer (
		.sys_clk (sys_clk),
		.sys_rst (sys_rst),
		.clk_en  (clk_en),
		.tif     (tif)
	);

	// Length of a phase under the latched config
	function automatic logic [LEN_W-1:0] phase_len(ebcs_phase_e ph, ebcs_cfg_s c, logic win_chg);
		logic [LEN_W-1:0] l;
		l = '0;
		unique case (ph)
			PH_ADDR: begin
				l = ADDR_BASE_LEN + LEN_W'(c.addr_setup) + (win_chg ? LEN_W'(c.window_ext) : '0);
			end
			PH_CMD:    l = LEN_W'(c.cmd_delay);
			PH_WSETUP: l = LEN_W'(c.write_setup);
			PH_ACCESS: l = ACCESS_MIN_LEN + LEN_W'(c.access);
			PH_HOLD:   l = LEN_W'(c.hold);
			PH_IDLE:   l = '0;
		endcase
		return l;
	endfunction

	// Next phase in fixed order, zero-length phases skipped
	function automatic ebcs_phase_e phase_next(ebcs_phase_e ph, ebcs_cfg_s c);
		ebcs_phase_e n;
		n = PH_IDLE;
		unique case (ph)
			PH_ADDR:   n = (c.cmd_delay != 2'h0) ? PH_CMD : (c.write_setup ? PH_WSETUP : PH_ACCESS);
			PH_CMD:    n = c.write_setup ? PH_WSETUP : PH_ACCESS;
			PH_WSETUP: n = PH_ACCESS;
			PH_ACCESS: n = (c.hold != 2'h0) ? PH_HOLD : PH_IDLE;
			PH_HOLD:   n = PH_IDLE;
			PH_IDLE:   n = PH_IDLE;
		endcase
		return n;
	endfunction

	// ****************************************
	// Sequencing
	// ****************************************
	logic       rdy_act;
	logic       win_chg;
	ebcs_cfg_s  new_cfg;

	always_comb begin
		s_d      = s_q;
		tif.load = 1'b0;
		tif.len  = '0;
		new_cfg  = cs_cfg[req_window[$clog2(NUM_CS)-1+((NUM_CS==1)?1:0):0]];
		win_chg  = !s_q.win_seen || (s_q.last_win != req_window);
		rdy_act  = (s_q.cfg.ready_async ? s_q.rdy_s[2] : s_q.rdy_s[1]) ^ s_q.cfg.ready_low;
		s_d.rsp_valid = 1'b0;
		// Pin inputs through two flops, handshake through a third when ready_async is set
		s_d.rdy_s = {s_q.rdy_s[1:0], ready_in};
		s_d.dd_s1 = dedicated_data_lines_in;
		s_d.dd_s2 = s_q.dd_s1;
		s_d.ad_s1 = shared_addr_data_lines_in;
		s_d.ad_s2 = s_q.ad_s1;
		s_d.refclk_en = reference_clock_output_sys_sel && reference_clock_output_fast_drv;
		unique case (s_q.phase)
			PH_IDLE: begin
				if (req_valid && s_q.req_ready && (int'(req_window) < NUM_CS)) begin
					s_d.phase    = PH_ADDR;
					s_d.write    = req_write;
					s_d.addr     = req_addr;
					s_d.wdata    = req_wdata;
					s_d.byte_high_enable      = req_byte_high;
					s_d.win      = req_window;
					s_d.last_win = req_window;
					s_d.win_seen = 1'b1;
					s_d.cfg      = new_cfg;
					tif.load     = 1'b1;
					tif.len      = phase_len(PH_ADDR, new_cfg, win_chg);
				end
			end
			PH_ACCESS: begin
				if (tif.last) begin
					if (s_q.cfg.ready_en && !rdy_act) begin
						tif.load = 1'b1;
						tif.len  = WAIT_LEN;
					end else begin
						s_d.phase = phase_next(PH_ACCESS, s_q.cfg);
						tif.load  = (s_d.phase != PH_IDLE);
						tif.len   = phase_len(s_d.phase, s_q.cfg, 1'b0);
						s_d.rsp_valid = 1'b1;
						if (!s_q.write) begin
							s_d.rsp_rdata = s_q.cfg.mux_mode ? s_q.ad_s2 : s_q.dd_s2;
						end
					end
				end
			end
			default: begin
				if (tif.last) begin
					s_d.phase = phase_next(s_q.phase, s_q.cfg);
					tif.load  = (s_d.phase != PH_IDLE);
					tif.len   = phase_len(s_d.phase, s_q.cfg, 1'b0);
				end
			end
		endcase
		// Pin values follow the phase being entered
		s_d.req_ready = (s_d.phase == PH_IDLE);
		s_d.cs_n      = '1;
		if (s_d.phase != PH_IDLE) s_d.cs_n[s_d.win[$clog2(NUM_CS)-1+((NUM_CS==1)?1:0):0]] = 1'b0;
		s_d.rd_n  = !((s_d.phase == PH_ACCESS) && !s_d.write);
		s_d.wr_n  = !((s_d.phase == PH_ACCESS) && s_d.write);
		s_d.bhe_n = !((s_d.phase != PH_IDLE) && s_d.byte_high_enable);
		s_d.ale   = (s_d.phase == PH_ADDR) && s_d.cfg.mux_mode;
		s_d.a_out = s_d.addr;
		s_d.d_oe  = !s_d.cfg.mux_mode && s_d.write &&
			((s_d.phase == PH_WSETUP) || (s_d.phase == PH_ACCESS) || (s_d.phase == PH_HOLD));
		s_d.d_out = s_d.wdata;
		if (s_d.cfg.mux_mode && ((s_d.phase == PH_ADDR) || (s_d.phase == PH_CMD))) begin
			s_d.ad_out = s_d.addr[DATA_W-1:0];
			s_d.ad_oe  = 1'b1;
		end else begin
			s_d.ad_out = s_d.wdata;
			s_d.ad_oe  = s_d.cfg.mux_mode && s_d.write && (s_d.phase != PH_IDLE) &&
				(s_d.phase != PH_WSETUP);
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			s_q           <= '0;
			s_q.phase     <= PH_IDLE;
			s_q.addr      <= ADDR_RST;
			s_q.a_out     <= ADDR_RST;
			s_q.rsp_rdata <= DATA_RST;
			s_q.cs_n      <= '1;
			s_q.rd_n      <= 1'b1;
			s_q.wr_n      <= 1'b1;
			s_q.bhe_n     <= 1'b1;
		end else if (clk_en) begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign req_ready                  = s_q.req_ready;
	assign rsp_valid                  = s_q.rsp_valid;
	assign rsp_rdata                  = s_q.rsp_rdata;
	assign cs_n                       = s_q.cs_n;
	assign rd_n                       = s_q.rd_n;
	assign wr_n                       = s_q.wr_n;
	assign byte_high_enable_n         = s_q.bhe_n;
	assign ale                        = s_q.ale;
	assign dedicated_address_lines    = s_q.a_out;
	assign dedicated_data_lines_out   = s_q.d_out;
	assign dedicated_data_lines_oe    = s_q.d_oe;
	assign shared_addr_data_lines_out = s_q.ad_out;
	assign shared_addr_data_lines_oe  = s_q.ad_oe;
	// Full-rate clock gated by a registered enable
	assign reference_clock_output     = sys_clk & s_q.refclk_en;
endmodule
`default_nettype wire

// ==== ebcs_seq_props.sv ====
// Purpose: Pin level checks on the bus cycle sequencer
// Assumes: One system clock per phase time unit
// Notes:   Bound to the sequencer from the bench file
`timescale 1ns/100ps
`default_nettype none
module ebcs_seq_props #(
	parameter int NUM_CS = 4
) (
	input wire logic                        sys_clk,
	input wire logic                        sys_rst,
	input wire logic                        req_valid,
	input wire logic                        req_ready,
	input wire logic [$clog2(NUM_CS+1)-1:0] req_window,
	input wire logic                        rsp_valid,
	input wire logic [NUM_CS-1:0]           cs_n,
	input wire logic                        rd_n,
	input wire logic                        wr_n,
	input wire logic                        ale,
	input wire logic                        dedicated_data_lines_oe,
	input wire logic                        shared_addr_data_lines_oe
);
	import ebcs_pkg::*;
	// ****
	// Cycle checks
	// ****
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_take;
		req_valid && req_ready && (req_window < NUM_CS);
	endsequence
	sequence s_strobe_end;
		$rose(rd_n) || $rose(wr_n);
	endsequence
	a_take_selects: assert property (
		s_take |=> !req_ready && $countones(~cs_n) == 1 && !cs_n[$past(req_window)])
		else $error("Window not selected after accept");
	a_end_completes: assert property (
		s_strobe_end |-> rsp_valid)
		else $error("Strobe ended without completion");
	a_rsp_single: assert property (
		rsp_valid |=> !rsp_valid)
		else $error("Completion longer than one cycle");
	a_idle_quiet: assert property (
		req_ready |-> (&cs_n) && rd_n && wr_n && !ale)
		else $error("Bus active while idle");
	a_strobe_in_cs: assert property (
		(!rd_n || !wr_n) |-> $countones(~cs_n) == 1 && (rd_n || wr_n) && !ale)
		else $error("Strobe outside one selected window");
	a_ale_shared: assert property (
		ale |-> shared_addr_data_lines_oe && $countones(~cs_n) == 1)
		else $error("Latch pulse without address on shared lines");
	a_write_drives: assert property (
		!wr_n |-> dedicated_data_lines_oe || shared_addr_data_lines_oe)
		else $error("Write strobe without driven data");
	a_access_bounded: assert property (
		$fell(rd_n) |-> !dedicated_data_lines_oe ##0 (##[1:40] $rose(rd_n)))
		else $error("Read access too long or lines driven");
endmodule
`default_nettype wire

// ==== ebcs_ext_mem.sv ====
// Purpose: Behavioural memory on the far side of the bus pins
// Assumes: Sixteen words picked by the low address nibble
// Notes:   Handshake goes active two link clock edges into a strobe
`timescale 1ns/100ps
`default_nettype none
module ebcs_ext_mem (
	input  wire logic                        ref_clk,
	input  wire logic                        lnk_clk,
	input  wire logic                        sel_n,
	input  wire logic                        rd_n,
	input  wire logic                        wr_n,
	input  wire logic                        ale,
	input  wire logic                        multiplexed_bus_mode,
	input  wire logic                        rdy_low,
	input  wire logic [ebcs_pkg::ADDR_W-1:0] addr,
	input  wire logic [ebcs_pkg::DATA_W-1:0] dd_out,
	input  wire logic                        dd_oe,
	input  wire logic [ebcs_pkg::DATA_W-1:0] ad_out,
	input  wire logic                        ad_oe,
	output logic      [ebcs_pkg::DATA_W-1:0] dd_pin,
	output logic      [ebcs_pkg::DATA_W-1:0] ad_pin,
	output logic                             ready_pin
);
	import ebcs_pkg::*;
	logic [DATA_W-1:0] mem [16];
	logic [DATA_W-1:0] last_d = 16'h0000;
	logic [3:0]        mux_addr = 4'h0;
	logic [1:0]        lnk_cnt = 2'h0;
	logic              drv;
	logic              strobe;
	logic [3:0]        idx;
	// ****
	// Pins
	// ****
	assign idx = multiplexed_bus_mode ? mux_addr : addr[3:0];
	assign drv = !sel_n && !rd_n;
	assign strobe = !rd_n || !wr_n;
	// Latch address, store writes, remember last read
	always @(posedge ref_clk) begin
		if (ale) begin
			mux_addr <= ad_pin[3:0];
		end
		if (!wr_n) begin
			mem[idx] <= multiplexed_bus_mode ? ad_pin : dd_pin;
		end
		if (drv) begin
			last_d <= mem[idx];
		end
	end
	// Read data only under the read strobe, inverted junk once released
	assign dd_pin = dd_oe ? dd_out : (drv && !multiplexed_bus_mode) ? mem[idx] : ~last_d;
	assign ad_pin = ad_oe ? ad_out : (drv && multiplexed_bus_mode) ? mem[idx] : ~last_d;
	// Count link edges; clear at once when the strobe ends
	always @(posedge lnk_clk or negedge strobe) begin
		if (!strobe) begin
			lnk_cnt <= 2'h0;
		end else if (lnk_cnt != 2'h2) begin
			lnk_cnt <= lnk_cnt + 2'h1;
		end
	end
	assign ready_pin = (strobe && lnk_cnt == 2'h2) ^ rdy_low;
endmodule
`default_nettype wire

// ==== ebcs_sequencer_bench.sv ====
// Purpose: Self-checking bench of the bus cycle sequencer
// Assumes: One system clock per phase time unit
// Notes:   Latency counts edges from accept to completion
`timescale 1ns/100ps
`default_nettype none
module ebcs_sequencer_bench;
	import ebcs_pkg::*;
	localparam int NUM_CS = 4;
	logic sys_clk = 1'h0;
	logic sys_rst = 1'h1;
	logic lnk_clk = 1'h0;
	logic clk_en = 1'h1;
	ebcs_cfg_s [NUM_CS-1:0] cs_cfg;
	logic reference_clock_output_sys_sel, reference_clock_output_fast_drv, req_valid, req_ready, req_write, req_byte_high, rsp_valid, rd_n, wr_n;
	logic byte_high_enable_n, ale, dedicated_data_lines_oe, shared_addr_data_lines_oe, ready_in;
	logic reference_clock_output, cur_mux, rdy_low;
	logic [2:0] req_window;
	logic [NUM_CS-1:0] cs_n;
	logic [ADDR_W-1:0] req_addr, dedicated_address_lines;
	logic [DATA_W-1:0] req_wdata, rsp_rdata, dedicated_data_lines_out, dedicated_data_lines_in;
	logic [DATA_W-1:0] shared_addr_data_lines_out, shared_addr_data_lines_in;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	ebcs_sequencer #(.NUM_CS(NUM_CS), .UNIT_CYCLES(1)) uut (
		.sys_clk, .sys_rst, .clk_en, .cs_cfg, .reference_clock_output_sys_sel, .reference_clock_output_fast_drv, .req_valid, .req_ready,
		.req_write, .req_addr, .req_wdata, .req_byte_high, .req_window, .rsp_valid, .rsp_rdata, .cs_n, .rd_n,
		.wr_n, .byte_high_enable_n, .ale, .dedicated_address_lines, .dedicated_data_lines_out,
		.dedicated_data_lines_oe, .dedicated_data_lines_in, .shared_addr_data_lines_out,
		.shared_addr_data_lines_oe, .shared_addr_data_lines_in, .ready_in, .reference_clock_output);
	ebcs_ext_mem u_mem (
		.ref_clk(reference_clock_output), .lnk_clk, .sel_n(&cs_n), .rd_n, .wr_n, .ale, .multiplexed_bus_mode(cur_mux), .rdy_low,
		.addr(dedicated_address_lines), .dd_out(dedicated_data_lines_out), .dd_oe(dedicated_data_lines_oe),
		.ad_out(shared_addr_data_lines_out), .ad_oe(shared_addr_data_lines_oe),
		.dd_pin(dedicated_data_lines_in), .ad_pin(shared_addr_data_lines_in), .ready_pin(ready_in));
	// ****
	// Clocks and run limit
	// ****
	initial forever #25 sys_clk = ~sys_clk;
	initial begin
		#7;
		forever #200 lnk_clk = ~lnk_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			complete_run();
		end
	end
	// ****
	// Shared tasks
	// ****
	task automatic complete_run;
		if (err_total == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// One access; for reads d is the expected data
	task automatic access(input logic [2:0] win, input logic wr, input logic [23:0] a, input logic [15:0] d,
			input int lo, input int hi, input int cs_exp);
		int n;
		int c;
		int b;
		logic done;
		b = 0;
		done = 1'h0;
		cur_mux = cs_cfg[win].mux_mode;
		rdy_low = cs_cfg[win].ready_low;
		@(negedge sys_clk);
		while (req_ready !== 1'h1) @(negedge sys_clk);
		req_valid = 1'h1;
		req_write = wr;
		req_addr = a;
		req_wdata = d;
		req_byte_high = a[0];
		req_window = win;
		@(negedge sys_clk);
		req_valid = 1'h0;
		// Accept edge is the first counted cycle
		n = 1;
		c = int'(cs_n[win] === 1'h0);
		do begin
			@(posedge sys_clk);
			#1;
			n += !done;
			c += (cs_n[win] === 1'h0);
			b += (!cur_mux && cs_n[win] === 1'h0 && {byte_high_enable_n, dedicated_address_lines} !== {!a[0], a});
			done |= (rsp_valid === 1'h1);
		end while (!done || cs_n[win] === 1'h0);
		chk("latency in range", 32'h1, 32'(n >= lo && n <= hi));
		if (cs_exp > 0) chk("select length", cs_exp, c);
		chk("address and byte enable", 32'h0, b);
		if (!wr) chk("read data", {16'h0, d}, {16'h0, rsp_rdata});
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reference_clock_output;
		@(negedge sys_clk);
		reference_clock_output_fast_drv = 1'h0;
		repeat (3) @(posedge sys_clk);
		#1 chk("clock gated", 32'h0, {31'h0, reference_clock_output});
		@(negedge sys_clk);
		reference_clock_output_fast_drv = 1'h1;
		repeat (3) @(posedge sys_clk);
		#1 chk("clock high", 32'h1, {31'h0, reference_clock_output});
		@(negedge sys_clk);
		#1 chk("clock low", 32'h0, {31'h0, reference_clock_output});
	endtask
	task automatic t_demultiplexed_bus_mode;
		access(3'h0, 1'h1, 24'h00_0003, 16'hbeef, 13, 13, 14);
		access(3'h0, 1'h0, 24'h00_0003, 16'hbeef, 10, 10, 11);
	endtask
	task automatic t_mux;
		access(3'h1, 1'h1, 24'h00_0107, 16'h5a3c, 7, 7, 7);
		access(3'h1, 1'h0, 24'h00_0107, 16'h5a3c, 7, 7, 7);
	endtask
	task automatic t_ready;
		access(3'h2, 1'h0, 24'h00_0003, 16'hbeef, 11, 30, 0);
		access(3'h3, 1'h0, 24'h00_0003, 16'hbeef, 12, 31, 0);
	endtask
	task automatic t_refuse;
		int n;
		n = 0;
		@(negedge sys_clk);
		req_valid = 1'h1;
		req_window = 3'h4;
		repeat (10) begin
			@(posedge sys_clk);
			#1 n += (rsp_valid !== 1'h0 || cs_n !== 4'hf || req_ready !== 1'h1);
		end
		@(negedge sys_clk);
		req_valid = 1'h0;
		chk("bad window ignored", 32'h0, n);
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		cs_cfg[0] = '{1'h0, 1'h1, 2'h3, 2'h2, 1'h1, 5'h03, 2'h2, 1'h0, 1'h0, 1'h0};
		cs_cfg[1] = '{1'h1, 1'h0, 2'h0, 2'h0, 1'h1, 5'h03, 2'h1, 1'h0, 1'h0, 1'h0};
		cs_cfg[2] = '{1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 5'h01, 2'h0, 1'h1, 1'h1, 1'h0};
		cs_cfg[3] = '{1'h0, 1'h0, 2'h0, 2'h0, 1'h0, 5'h01, 2'h0, 1'h1, 1'h0, 1'h1};
		{reference_clock_output_sys_sel, reference_clock_output_fast_drv, req_valid, req_write, req_byte_high, cur_mux, rdy_low} = 7'h60;
		{req_window, req_addr, req_wdata} = '0;
		repeat (6) @(negedge sys_clk);
		sys_rst = 1'h0;
		@(posedge sys_clk);
		#1 chk("idle after reset", 32'h1f, {27'h0, req_ready, cs_n});
		t_reference_clock_output();
		t_demultiplexed_bus_mode();
		t_mux();
		t_ready();
		t_refuse();
		complete_run();
	end
endmodule
bind ebcs_sequencer ebcs_seq_props #(.NUM_CS(NUM_CS)) u_props (
	.sys_clk, .sys_rst, .req_valid, .req_ready, .req_window, .rsp_valid, .cs_n, .rd_n, .wr_n, .ale,
	.dedicated_data_lines_oe, .shared_addr_data_lines_oe);
`default_nettype wire
